/* File: sldc_pkg.sv */
package sldc_pkg;
	// ----------------------------------------
	// sizes and timing
	// ----------------------------------------
	localparam int SLDC_CHANNELS = 8;
	localparam int SLDC_FIFO_DEPTH = 8;
	localparam int SLDC_CLK_PERIOD_PS = 5000;
	localparam int SLDC_SCLK_HIGH_PS = 150000;
	localparam int SLDC_STROBE_GAP_PS = 300000;
	localparam int SLDC_STROBE_HIGH_PS = 100000;
	// least times round up
	localparam int SLDC_SCLK_HIGH_CYC = (SLDC_SCLK_HIGH_PS + SLDC_CLK_PERIOD_PS - 1) / SLDC_CLK_PERIOD_PS;
	localparam int SLDC_STROBE_GAP_CYC = (SLDC_STROBE_GAP_PS + SLDC_CLK_PERIOD_PS - 1) / SLDC_CLK_PERIOD_PS;
	localparam int SLDC_STROBE_HIGH_CYC = (SLDC_STROBE_HIGH_PS + SLDC_CLK_PERIOD_PS - 1) / SLDC_CLK_PERIOD_PS;
	localparam int SLDC_CNT_W = 8;
	localparam logic [7:0] SLDC_ZERO_BYTE = 8'h00;
	localparam logic [7:0] SLDC_OFF_BYTE = 8'h00;
	localparam logic [SLDC_CNT_W-1:0] SLDC_CNT_ZERO = 8'h00;
	localparam logic [2:0] SLDC_LAST_BIT = 3'h7;
	localparam logic [2:0] SLDC_BIT_ZERO = 3'h0;
endpackage : sldc_pkg

/* File: sldc_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface sldc_if;
	logic sclk;
	logic sdata;
	logic clear;
	logic strobe;
	logic oe_reset;
	logic sdout;
	logic flag_out;
	logic flag_oe_n;
	// open-drain flag: low while enable is low, else pulled up
	wire flag_n = flag_oe_n ? 1'b1 : flag_out;
	modport dev (
		input sclk, sdata, clear, strobe, oe_reset,
		output sdout, flag_out, flag_oe_n
	);
	modport host (
		output sclk, sdata, clear, strobe, oe_reset,
		input sdout, flag_n
	);
endinterface : sldc_if
`default_nettype wire

/* File: sldc_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module sldc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic nrst_i,
	// fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0] cnt_r;
	logic push;
	logic pop;
	logic [AW:0] cnt_nxt;
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
	assign out_valid_o = (cnt_r != '0);
	assign out_data_o = mem_r[rp_r];
	always_ff @(posedge core_clk_i) begin
		if (push) begin
			mem_r[wp_r] <= in_data_i;
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
			in_ready_o <= 1'b0;
		end else begin
			if (push) begin
				wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
			end
			if (pop) begin
				rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
			end
			cnt_r <= cnt_nxt;
			in_ready_o <= (cnt_nxt != DEPTH[AW:0]);
		end
	end
endmodule : sldc_fifo
`default_nettype wire

/* File: sldc_dev.sv */
`timescale 1ns/1ps
`default_nettype none
// Contract
// - rising serial clock captures data into stage one
// - stages shift toward serial output each edge
// - clear high shifts zeros in
// - strobe high transparent, low holds latch
// - latches follow shifts while strobe high
// - host disables outputs when strobe tied high
// - enable high forces outputs off, keeps contents
// - enable low drives outputs from latch bits
// - overcurrent latched until enable high pulse
// - overtemperature fault self clears, not latched
// - serial clock high at least 150ns
// - strobe waits 300ns after last clock
// - strobe high at least 100ns
// - flag pulled low on any fault except undervoltage
// - undervoltage acts as enable high
module sldc_dev
	import sldc_pkg::*;
(
	// clock and reset
	input wire logic core_clk_i,
	input wire logic nrst_i,
	// link
	sldc_if.dev link,
	// fault inputs from analog sense
	input wire logic [SLDC_CHANNELS-1:0] ocur_i,
	input wire logic otemp_i,
	input wire logic uvlo_i,
	// driver outputs, high = channel on, and latch copy
	output logic [SLDC_CHANNELS-1:0] drv_on_o,
	output logic [SLDC_CHANNELS-1:0] latch_o
);
	// ----------------------------------------
	// link pin synchronisers
	// ----------------------------------------
	localparam int NL = 5;
	logic [NL-1:0] pin1_r;
	logic [NL-1:0] pin2_r;
	// first stage feeds only the second
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			pin1_r <= '0;
			pin2_r <= '0;
		end else begin
			pin1_r <= {link.sclk, link.sdata, link.clear, link.strobe, link.oe_reset};
			pin2_r <= pin1_r;
		end
	end
	logic sclk_s, sdata_s, clear_s, strobe_s, oe_s;
	assign {sclk_s, sdata_s, clear_s, strobe_s, oe_s} = pin2_r;
	// ----------------------------------------
	// fault sense synchronisers
	// ----------------------------------------
	localparam int NF = SLDC_CHANNELS + 2;
	logic [NF-1:0] sense1_r;
	logic [NF-1:0] sense2_r;
	// analog sense levels arrive unclocked
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			sense1_r <= '0;
			sense2_r <= '0;
		end else begin
			sense1_r <= {ocur_i, otemp_i, uvlo_i};
			sense2_r <= sense1_r;
		end
	end
	logic otemp_s, uvlo_s;
	logic [SLDC_CHANNELS-1:0] ocur_s;
	assign {ocur_s, otemp_s, uvlo_s} = sense2_r;
	// ----------------------------------------
	// clock edge detect
	// ----------------------------------------
	// idle low, so no false edge after reset
	logic sclk_d_r;
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			sclk_d_r <= 1'b0;
		end else begin
			sclk_d_r <= sclk_s;
		end
	end
	logic sclk_rise;
	logic disable_all;
	assign sclk_rise = sclk_s && !sclk_d_r;
	assign disable_all = oe_s || uvlo_s;
	// ----------------------------------------
	// shift register
	// ----------------------------------------
	logic [SLDC_CHANNELS-1:0] shreg_r;
	logic [SLDC_CHANNELS-1:0] shreg_nxt;
	always_comb begin
		shreg_nxt = shreg_r;
		if (sclk_rise) begin
			shreg_nxt = {shreg_r[SLDC_CHANNELS-2:0], sdata_s};
			if (clear_s) begin
				shreg_nxt = {shreg_r[SLDC_CHANNELS-2:0], 1'b0};
			end
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			shreg_r <= SLDC_ZERO_BYTE;
		end else begin
			shreg_r <= shreg_nxt;
		end
	end
	// ----------------------------------------
	// serial output
	// ----------------------------------------
	// stage eight as it shifts, for cascading
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			link.sdout <= 1'b0;
		end else begin
			link.sdout <= shreg_nxt[SLDC_CHANNELS-1];
		end
	end
	// ----------------------------------------
	// output latches
	// ----------------------------------------
	logic [SLDC_CHANNELS-1:0] latch_r;
	logic [SLDC_CHANNELS-1:0] latch_nxt;
	// transparent while strobe high
	assign latch_nxt = strobe_s ? shreg_nxt : latch_r;
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			latch_r <= SLDC_ZERO_BYTE;
		end else begin
			latch_r <= latch_nxt;
		end
	end
	// ----------------------------------------
	// latch copy port
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			latch_o <= SLDC_ZERO_BYTE;
		end else begin
			latch_o <= latch_nxt;
		end
	end
	// ----------------------------------------
	// overcurrent latches, one per channel
	// ----------------------------------------
	wire logic [SLDC_CHANNELS-1:0] oc_lat_nxt;
	wire logic [SLDC_CHANNELS-1:0] drv_nxt;
	logic drv_block;
	// enable, undervoltage or heat blanks all
	assign drv_block = disable_all || otemp_s;
	for (genvar ch = 0; ch < SLDC_CHANNELS; ch++) begin : g_chan
		logic lat_r;
		logic lat_nxt;
		// set wins over a clear in the same cycle
		always_comb begin
			lat_nxt = lat_r;
			if (ocur_s[ch]) begin
				lat_nxt = 1'b1;
			end else if (disable_all) begin
				lat_nxt = 1'b0;
			end
		end
		always_ff @(posedge core_clk_i) begin
			if (!nrst_i) begin
				lat_r <= 1'b0;
			end else begin
				lat_r <= lat_nxt;
			end
		end
		assign oc_lat_nxt[ch] = lat_nxt;
		assign drv_nxt[ch] = latch_nxt[ch] && !lat_nxt;
	end : g_chan
	// ----------------------------------------
	// drivers
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			drv_on_o <= SLDC_OFF_BYTE;
		end else if (drv_block) begin
			drv_on_o <= SLDC_OFF_BYTE;
		end else begin
			drv_on_o <= drv_nxt;
		end
	end
	// ----------------------------------------
	// fault flag pin
	// ----------------------------------------
	// open drain: only ever pulls low
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			link.flag_oe_n <= 1'b1;
		end else begin
			link.flag_oe_n <= !((|oc_lat_nxt) || otemp_s);
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			link.flag_out <= 1'b0;
		end else begin
			link.flag_out <= 1'b0;
		end
	end
endmodule : sldc_dev
`default_nettype wire

/* File: sldc_host.sv */
`timescale 1ns/1ps
`default_nettype none
module sldc_host
	import sldc_pkg::*;
(
	// clock and reset
	input wire logic core_clk_i,
	input wire logic nrst_i,
	// byte requests
	input wire logic req_valid_i,
	output logic req_ready_o,
	input wire logic [7:0] req_data_i,
	input wire logic req_clear_i,
	// enable control
	input wire logic out_enable_i,
	// status
	output logic busy_o,
	output logic fault_o,
	output logic sdout_o,
	// link
	sldc_if.host link
);
	// ----------------------------------------
	// request buffer
	// ----------------------------------------
	logic f_valid;
	logic f_pop;
	logic [8:0] f_data;
	sldc_fifo #(.WIDTH(9), .DEPTH(SLDC_FIFO_DEPTH)) u_fifo (
		.core_clk_i(core_clk_i),
		.nrst_i(nrst_i),
		.in_valid_i(req_valid_i),
		.in_ready_o(req_ready_o),
		.in_data_i({req_clear_i, req_data_i}),
		.out_valid_o(f_valid),
		.out_ready_i(f_pop),
		.out_data_o(f_data)
	);
	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	typedef enum logic [2:0] {
		SLDC_IDLE = 3'h0,
		SLDC_LOW = 3'h1,
		SLDC_HIGH = 3'h2,
		SLDC_GAP = 3'h3,
		SLDC_STB = 3'h4
	} sldc_state_t;
	sldc_state_t st_r;
	logic [SLDC_CNT_W-1:0] cnt_r;
	logic [2:0] bit_r;
	logic [8:0] cur_r;
	assign f_pop = (st_r == SLDC_IDLE) && f_valid;
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			st_r <= SLDC_IDLE;
			cnt_r <= SLDC_CNT_ZERO;
			bit_r <= SLDC_BIT_ZERO;
			cur_r <= '0;
		end else begin
			unique case (st_r)
				SLDC_IDLE: begin
					if (f_valid) begin
						cur_r <= f_data;
						bit_r <= SLDC_BIT_ZERO;
						cnt_r <= SLDC_CNT_W'(SLDC_SCLK_HIGH_CYC - 1);
						st_r <= SLDC_LOW;
					end
				end
				SLDC_LOW: begin
					if (cnt_r == SLDC_CNT_ZERO) begin
						cnt_r <= SLDC_CNT_W'(SLDC_SCLK_HIGH_CYC - 1);
						st_r <= SLDC_HIGH;
					end else begin
						cnt_r <= cnt_r - 1'b1;
					end
				end
				SLDC_HIGH: begin
					if (cnt_r != SLDC_CNT_ZERO) begin
						cnt_r <= cnt_r - 1'b1;
					end else if (bit_r == SLDC_LAST_BIT) begin
						cnt_r <= SLDC_CNT_W'(SLDC_STROBE_GAP_CYC - 1);
						st_r <= SLDC_GAP;
					end else begin
						bit_r <= bit_r + 1'b1;
						cnt_r <= SLDC_CNT_W'(SLDC_SCLK_HIGH_CYC - 1);
						st_r <= SLDC_LOW;
					end
				end
				SLDC_GAP: begin
					if (cnt_r == SLDC_CNT_ZERO) begin
						cnt_r <= SLDC_CNT_W'(SLDC_STROBE_HIGH_CYC - 1);
						st_r <= SLDC_STB;
					end else begin
						cnt_r <= cnt_r - 1'b1;
					end
				end
				SLDC_STB: begin
					if (cnt_r == SLDC_CNT_ZERO) begin
						st_r <= SLDC_IDLE;
					end else begin
						cnt_r <= cnt_r - 1'b1;
					end
				end
				default: begin
					st_r <= SLDC_IDLE;
				end
			endcase
		end
	end
	// ----------------------------------------
	// link pins, msb first
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			link.sclk <= 1'b0;
			link.sdata <= 1'b0;
			link.clear <= 1'b0;
			link.strobe <= 1'b0;
			link.oe_reset <= 1'b1;
		end else begin
			link.sclk <= (st_r == SLDC_HIGH);
			link.sdata <= cur_r[SLDC_LAST_BIT - bit_r];
			link.clear <= cur_r[SLDC_CHANNELS];
			link.strobe <= (st_r == SLDC_STB);
			link.oe_reset <= !out_enable_i;
		end
	end
	// ----------------------------------------
	// status from pins
	// ----------------------------------------
	logic [1:0] fs1_r;
	logic [1:0] fs2_r;
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			fs1_r <= 2'h0;
			fs2_r <= 2'h0;
			busy_o <= 1'b0;
			fault_o <= 1'b0;
			sdout_o <= 1'b0;
		end else begin
			fs1_r <= {!link.flag_n, link.sdout};
			fs2_r <= fs1_r;
			busy_o <= (st_r != SLDC_IDLE) || f_valid;
			fault_o <= fs2_r[1];
			sdout_o <= fs2_r[0];
		end
	end
endmodule : sldc_host
`default_nettype wire

/* File: sldc_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module sldc_properties
	import sldc_pkg::*;
(
	// clock and reset
	input wire logic core_clk_i,
	input wire logic nrst_i,
	// host pins
	input wire logic sclk,
	input wire logic sdata,
	input wire logic clear,
	input wire logic strobe,
	input wire logic oe_reset,
	// device pins
	input wire logic sdout,
	input wire logic flag_out,
	input wire logic flag_oe_n,
	// fault sense levels
	input wire logic [7:0] ocur,
	input wire logic otemp
);
	// ----------------------------------------
	// pin level shadow and width counters
	// ----------------------------------------
	logic sclk_q_r;
	logic [7:0] shadow_r;
	logic [7:0] hi_cnt_r;
	logic [7:0] lo_cnt_r;
	logic [7:0] st_cnt_r;
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!nrst_i);
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			sclk_q_r <= 1'b0;
			shadow_r <= 8'h00;
		end else begin
			sclk_q_r <= sclk;
			if (sclk && !sclk_q_r) begin
				shadow_r <= {shadow_r[6:0], sdata & ~clear};
			end
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			hi_cnt_r <= 8'h00;
			lo_cnt_r <= 8'h00;
			st_cnt_r <= 8'h00;
		end else begin
			hi_cnt_r <= sclk ? hi_cnt_r + {7'h00, hi_cnt_r != 8'hFF} : 8'h00;
			lo_cnt_r <= sclk ? 8'h00 : lo_cnt_r + {7'h00, lo_cnt_r != 8'hFF};
			st_cnt_r <= strobe ? st_cnt_r + {7'h00, st_cnt_r != 8'hFF} : 8'h00;
		end
	end
	// ----------------------------------------
	// checks
	// ----------------------------------------
	shift_capture_a: assert property ($rose(sclk) |-> ##4 sdout == shadow_r[7])
		else $error("serial output differs from shifted chain");
	sdout_quiet_a: assert property ($changed(sdout) |->
		$past(sclk, 2) || $past(sclk, 3) || $past(sclk, 4))
		else $error("serial output moved without a clock");
	chain_at_strobe_a: assert property ($rose(strobe) |-> sdout == shadow_r[7])
		else $error("serial output wrong at strobe");
	sclk_width_a: assert property ($fell(sclk) |-> hi_cnt_r >= SLDC_SCLK_HIGH_CYC)
		else $error("clock pulse too short");
	strobe_gap_a: assert property ($rose(strobe) |-> lo_cnt_r >= SLDC_STROBE_GAP_CYC)
		else $error("strobe too soon after clock");
	strobe_width_a: assert property ($fell(strobe) |-> st_cnt_r >= SLDC_STROBE_HIGH_CYC)
		else $error("strobe pulse too short");
	flag_drain_a: assert property (!flag_out)
		else $error("flag driven high");
	data_hold_a: assert property (sclk |-> $stable(sdata) && $stable(clear))
		else $error("data moved while clock high");
	fault_flag_a: assert property ((otemp || ocur != 8'h00) |-> ##3 !flag_oe_n)
		else $error("flag not pulled low on fault");
	flag_clear_a: assert property ($rose(oe_reset) && ocur == 8'h00 && !otemp |-> ##3 flag_oe_n)
		else $error("flag not released by enable pulse");
endmodule : sldc_properties
`default_nettype wire

/* File: sldc_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module sldc_tb_top;
	logic core_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic req_valid = 1'b0;
	logic req_clear = 1'b0;
	logic out_en = 1'b0;
	logic otemp = 1'b0;
	logic uvlo = 1'b0;
	logic [7:0] req_data = 8'h00;
	logic [7:0] ocur = 8'h00;
	logic req_ready, busy, fault, sdout_h;
	logic [7:0] drv, latch;
	int n_fail = 0;
	int cmp_count = 0;
	int refused = 0;
	// status: fault, serial out, latch, drivers
	wire logic [23:0] st = {6'h00, fault, sdout_h, latch, drv};
	always #2.5 core_clk_i = ~core_clk_i;
	sldc_if u_sldc_if ();
	sldc_host u_sldc_host (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .req_valid_i(req_valid),
		.req_ready_o(req_ready), .req_data_i(req_data), .req_clear_i(req_clear),
		.out_enable_i(out_en), .busy_o(busy), .fault_o(fault), .sdout_o(sdout_h),
		.link(u_sldc_if));
	sldc_dev u_sldc_dev (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .link(u_sldc_if),
		.ocur_i(ocur), .otemp_i(otemp), .uvlo_i(uvlo), .drv_on_o(drv), .latch_o(latch));
	sldc_properties u_sldc_properties (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
		.sclk(u_sldc_if.sclk), .sdata(u_sldc_if.sdata), .clear(u_sldc_if.clear),
		.strobe(u_sldc_if.strobe), .oe_reset(u_sldc_if.oe_reset), .sdout(u_sldc_if.sdout),
		.flag_out(u_sldc_if.flag_out), .flag_oe_n(u_sldc_if.flag_oe_n),
		.ocur(ocur), .otemp(otemp));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic finish_test();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : finish_test
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wt(input int n);
		repeat (n) @(negedge core_clk_i);
	endtask : wt
	task automatic send(input logic [7:0] d, input logic c, input logic last);
		req_valid = 1'b1;
		req_data = d;
		req_clear = c;
		while (req_ready !== 1'b1) begin
			refused++;
			wt(1);
		end
		wt(1);
		if (last) req_valid = 1'b0;
	endtask : send
	task automatic idle();
		int n;
		int q;
		n = 0;
		q = 0;
		wt(4);
		while (q < 4 && n < 20000) begin
			wt(1);
			n++;
			q = (busy === 1'b0) ? q + 1 : 0;
		end
		if (n >= 20000) n_fail++;
	endtask : idle
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		wt(20);
		nrst_i = 1'b1;
		wt(2);
		out_en = 1'b1;
		send(8'hA5, 1'b0, 1'b1);
		idle();
		chk(st, 24'h01A5A5);
		$display("test basic done");
		send(8'h3C, 1'b0, 1'b1);
		wt(100);
		chk(24'(latch), 24'h0000A5);
		idle();
		chk(st, 24'h003C3C);
		$display("test hold done");
		for (int i = 0; i < 10; i++) send(8'(i * 8'h13 + 8'hE0), 1'b0, i == 9);
		chk(24'(refused != 0), 24'h000001);
		idle();
		chk(st, 24'h018B8B);
		$display("test fifo done");
		send(8'hFF, 1'b1, 1'b1);
		idle();
		chk(st, 24'h000000);
		$display("test clear done");
		send(8'hFF, 1'b0, 1'b1);
		idle();
		out_en = 1'b0;
		wt(12);
		chk(st, 24'h01FF00);
		out_en = 1'b1;
		wt(12);
		chk(st, 24'h01FFFF);
		$display("test enable done");
		ocur = 8'h04;
		wt(12);
		ocur = 8'h00;
		wt(12);
		chk(st, 24'h03FFFB);
		out_en = 1'b0;
		wt(12);
		out_en = 1'b1;
		wt(12);
		chk(st, 24'h01FFFF);
		$display("test overcurrent done");
		otemp = 1'b1;
		wt(12);
		chk(st, 24'h03FF00);
		otemp = 1'b0;
		wt(12);
		chk(st, 24'h01FFFF);
		$display("test overtemp done");
		ocur = 8'h01;
		wt(12);
		ocur = 8'h00;
		wt(12);
		chk(st, 24'h03FFFE);
		uvlo = 1'b1;
		wt(12);
		chk(st, 24'h01FF00);
		uvlo = 1'b0;
		wt(12);
		chk(st, 24'h01FFFF);
		$display("test undervoltage done");
		finish_test();
	end
	// about 8k cycles of traffic, seven times that as margin
	initial begin
		#300000;
		n_fail++;
		finish_test();
	end
endmodule : sldc_tb_top
`default_nettype wire
